/* rtl/adc_parallel_output_port.sv */
// Overview of operation
// - Delay-lock loop enabled after reset.
// - Absent or slow clock forces power-down.
// - Default settings work above 2 MHz.
// - 12-bit word, highest line is MSB.
// - Flag high when word at full scale.
// - Ready clock with selectable capture polarity.
// - Four select levels choose coding and polarity.
// - Output enable low tri-states all outputs.
// - Positive overdrive gives FFF or 7FF.
// - Negative overdrive gives 000 or 800.
// - Commanded power-down tri-states, keeps reference.
// - Reset clears all but loop and clock-lost status, data outputs low.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Parallel output port of a 12-bit converter
module adc_parallel_output_port #(
  parameter int SAMPLE_W   = adc_out_pkg::SAMPLE_W,   // Word width
  parameter int FIFO_DEPTH = adc_out_pkg::FIFO_DEPTH  // Words buffered
) (
  // Clock and reset
  input  wire logic                i_mclk,
  input  wire logic                i_rstn,
  // Sample clock pin, sampled here
  input  wire logic                i_sample_clk,
  // Static configuration pins
  input  wire logic [1:0]          i_format_polarity_select,
  input  wire logic                i_output_enable,
  // Configuration bits from the control logic
  input  wire logic                i_dll_off,
  input  wire logic                i_power_down_bit,
  // Conversion core stream
  input  wire logic                i_conv_valid,
  output logic                     o_conv_ready,
  input  wire logic [SAMPLE_W-1:0] i_conv_code,
  input  wire logic                i_conv_ovr_pos,
  input  wire logic                i_conv_ovr_neg,
  // Sample word pins
  output logic [SAMPLE_W-1:0]      o_sample_data,
  output logic [SAMPLE_W-1:0]      o_sample_data_oe,
  // Out of range flag pin
  output logic                     o_out_of_range_flag,
  output logic                     o_out_of_range_flag_oe,
  // Data ready clock pin
  output logic                     o_data_ready_clock,
  output logic                     o_data_ready_clock_oe,
  // Status
  output logic                     o_dll_enabled,
  output logic                     o_core_active,
  output logic                     o_reference_on,
  output logic                     o_clock_lost
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Synchronised pin levels: sample clock, enable and select
  logic [3:0]                    pins_sync;
  logic                          sclk_s;       // Sample clock level
  logic                          oe_s;         // Output enable level
  logic [1:0]                    fmt_s;        // Format and polarity select
  logic                          sclk_d_r;     // Sample clock one cycle later
  logic                          sclk_rise;    // Rising edge seen
  logic                          sclk_edge;    // Any edge seen

  // Clock gap watch
  logic [adc_out_pkg::GAP_CNT_W-1:0] gap_cnt_r;
  logic                          gap_expired;

  // Power state
  adc_out_pkg::pwr_state_t       pwr_r;
  adc_out_pkg::pwr_state_t       pwr_nxt;

  // Stream through the buffer
  adc_out_pkg::conv_word_t       conv_in;
  adc_out_pkg::conv_word_t       conv_out;
  logic                          fifo_valid;
  logic                          pop;

  // Encoded word
  adc_out_pkg::port_word_t       enc;
  logic [SAMPLE_W-1:0]           ob_code;      // Clamped offset binary

  // Output registers
  logic [SAMPLE_W-1:0]           data_r;
  logic                          ovr_r;
  logic                          ready_clk_r;
  logic                          drive_r;      // Pins driven
  logic                          dll_en_r;
  logic                          ref_on_r;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Sample clock, enable and select come from outside the block clock;
  // logic reads them only after the second stage
  sync_stage #(
    .WIDTH (4)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rstn  (i_rstn),
    .i_async ({i_sample_clk, i_output_enable, i_format_polarity_select}),
    .o_sync  (pins_sync)
  );

  assign sclk_s = pins_sync[3];
  assign oe_s   = pins_sync[2];
  assign fmt_s  = pins_sync[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Edge finder on the synchronised sample clock
  // Same reset level as the synchroniser, so reset alone makes no edge
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_d_r <= 1'h0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d_r;
  assign sclk_edge = sclk_s != sclk_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // Gap counter: cycles since the last sample clock edge, saturating
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      gap_cnt_r <= '0;
    end else if (sclk_edge) begin
      // Edge restarts the watch
      gap_cnt_r <= '0;
    end else if (!gap_expired) begin
      // Count until the limit, then hold
      gap_cnt_r <= gap_cnt_r + 1'h1;
    end
  end

  // Gap limit at the counter's width; the counter stops there, so it never wraps
  localparam logic [adc_out_pkg::GAP_CNT_W-1:0] GAP_LIMIT =
    adc_out_pkg::GAP_CNT_W'(adc_out_pkg::SLOW_CLK_GAP_CYC);

  // Clock slower than the guaranteed floor or stopped
  assign gap_expired = (gap_cnt_r >= GAP_LIMIT);

  //////////////////////////////////////////////////////////////////////////////
  // Power state: commanded power-down wins over clock loss
  // Clock loss keeps the pins driven with the last word; only the command or enable low releases them
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      adc_out_pkg::PWR_ACTIVE: begin
        if (i_power_down_bit) begin
          pwr_nxt = adc_out_pkg::PWR_COMMANDED_DOWN;
        end else if (gap_expired) begin
          pwr_nxt = adc_out_pkg::PWR_CLOCK_LOST;
        end
      end
      adc_out_pkg::PWR_CLOCK_LOST: begin
        if (i_power_down_bit) begin
          pwr_nxt = adc_out_pkg::PWR_COMMANDED_DOWN;
        end else if (sclk_edge) begin
          // Clock back: resume
          pwr_nxt = adc_out_pkg::PWR_ACTIVE;
        end
      end
      adc_out_pkg::PWR_COMMANDED_DOWN: begin
        if (!i_power_down_bit) begin
          // Leave through clock check
          pwr_nxt = gap_expired ? adc_out_pkg::PWR_CLOCK_LOST : adc_out_pkg::PWR_ACTIVE;
        end
      end
      default: begin
        pwr_nxt = adc_out_pkg::PWR_CLOCK_LOST;
      end
    endcase
  end

  // State register; asleep until a clock is seen
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pwr_r <= adc_out_pkg::PWR_CLOCK_LOST;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Buffer between conversion core and port
  assign conv_in.code    = i_conv_code;
  assign conv_in.ovr_pos = i_conv_ovr_pos;
  assign conv_in.ovr_neg = i_conv_ovr_neg;

  // One word leaves on each rising sample clock edge while active
  assign pop = sclk_rise && (pwr_r == adc_out_pkg::PWR_ACTIVE);

  // A full buffer refuses the core; words wait there and are never dropped
  sample_fifo #(
    .WIDTH ($bits(adc_out_pkg::conv_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_conv_valid),
    .o_in_ready  (o_conv_ready),
    .i_in_data   (conv_in),
    .o_out_valid (fifo_valid),
    .i_out_ready (pop),
    .o_out_data  (conv_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Encoder: overdrive clamp, coding choice, range flag
  always_comb begin
    if (conv_out.ovr_pos) begin
      ob_code = adc_out_pkg::CODE_POS_FULL;
    end else if (conv_out.ovr_neg) begin
      ob_code = adc_out_pkg::CODE_NEG_FULL;
    end else begin
      ob_code = conv_out.code;
    end
    // Flag set at either full scale limit
    enc.out_of_range_flag = (ob_code == adc_out_pkg::CODE_POS_FULL) ||
              (ob_code == adc_out_pkg::CODE_NEG_FULL);
    if (fmt_s[adc_out_pkg::FMT_TWOS_POS]) begin
      // MSB flip maps mid-scale to zero, FFF to 7FF and 000 to 800
      enc.data = ob_code ^ adc_out_pkg::CODE_TC_FLIP;
    end else begin
      enc.data = ob_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sample and flag registers; an empty buffer holds the last word
  // Clock loss and the command both stop pops, so the pins freeze on the last word
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_r <= adc_out_pkg::DATA_RST;
      ovr_r  <= 1'h0;
    end else if (pop && fifo_valid) begin
      data_r <= enc.data;
      ovr_r  <= enc.out_of_range_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data ready clock: its capture edge falls mid-word
  // Runs in every power state; it stands still only while the sample clock does
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_clk_r <= 1'h0;
    end else if (fmt_s[adc_out_pkg::FMT_FALL_POS]) begin
      // Falling edge capture: falls half a sample period after data change
      ready_clk_r <= sclk_s;
    end else begin
      // Rising edge capture: rises half a sample period after data change
      ready_clk_r <= !sclk_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output drive: enable pin high and no commanded power-down
  // The command acts through the next state, so drive changes on the same edge as the state
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      drive_r <= 1'h0;
    end else begin
      drive_r <= oe_s && (pwr_nxt != adc_out_pkg::PWR_COMMANDED_DOWN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loop mode and reference status
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      dll_en_r <= 1'h1;
      ref_on_r <= 1'h0;
    end else begin
      // Loop off only by configuration; the controller picks it below 60 MSPS
      dll_en_r <= !i_dll_off;
      // Reference stays on in every power state once out of reset
      ref_on_r <= 1'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port assignments
  // Word, flag and ready clock pins share one drive enable
  assign o_sample_data          = data_r;
  assign o_sample_data_oe       = {SAMPLE_W{drive_r}};
  assign o_out_of_range_flag    = ovr_r;
  assign o_out_of_range_flag_oe = drive_r;
  assign o_data_ready_clock     = ready_clk_r;
  assign o_data_ready_clock_oe  = drive_r;
  // Status seen by the control logic
  assign o_dll_enabled          = dll_en_r;
  assign o_core_active          = (pwr_r == adc_out_pkg::PWR_ACTIVE);
  assign o_reference_on         = ref_on_r;
  assign o_clock_lost           = (pwr_r == adc_out_pkg::PWR_CLOCK_LOST);

endmodule : adc_parallel_output_port
`default_nettype wire

/* shared/adc_out_pkg.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the converter output port
package adc_out_pkg;

  // Widths and depths
  localparam int SAMPLE_W   = 12;              // Converter word width
  localparam int FIFO_DEPTH = 4;               // Words buffered ahead of the port
  localparam int GAP_CNT_W  = 8;               // Width of the clock gap counter

  // Clock of the block
  localparam int MCLK_MHZ = 100;               // Block clock rate in MHz

  // Slow clock detection: half period of the slowest guaranteed clock (2 MHz)
  localparam int SLOW_CLK_GAP_NS  = 250;       // Longest legal gap between edges
  localparam int SLOW_CLK_GAP_RAW = (SLOW_CLK_GAP_NS * MCLK_MHZ) / 1000;
  localparam int SLOW_CLK_GAP_CYC = (SLOW_CLK_GAP_RAW < 1) ? 1 : SLOW_CLK_GAP_RAW;

  // Full scale codes in offset binary, and the MSB flip for two's complement
  localparam logic [SAMPLE_W-1:0] CODE_POS_FULL = 12'hfff;
  localparam logic [SAMPLE_W-1:0] CODE_NEG_FULL = 12'h000;
  localparam logic [SAMPLE_W-1:0] CODE_TC_FLIP  = 12'h800;

  // Reset values
  localparam logic [SAMPLE_W-1:0] DATA_RST = 12'h000;

  // Field positions inside the format and polarity select
  localparam int FMT_FALL_POS = 0;             // 1: capture on falling edge
  localparam int FMT_TWOS_POS = 1;             // 1: two's complement coding

  // Power states of the port
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_CLOCK_LOST,
    PWR_COMMANDED_DOWN
  } pwr_state_t;

  // Word from the conversion core
  typedef struct packed {
    logic [SAMPLE_W-1:0] code;                 // Offset binary result
    logic                ovr_pos;              // Positive overdrive
    logic                ovr_neg;              // Negative overdrive
  } conv_word_t;

  // Word as presented on the port
  typedef struct packed {
    logic [SAMPLE_W-1:0] data;                 // Encoded sample
    logic                out_of_range_flag;                  // Out of range flag
  } port_word_t;

endpackage : adc_out_pkg
`default_nettype wire

/* rtl/sync_stage.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Two flip-flop synchroniser for a group of pin levels
module sync_stage #(
  parameter int WIDTH = 1                      // Number of levels carried
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  // Levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;                    // First stage, read only by the second

  //////////////////////////////////////////////////////////////////////////////
  // Two stages in series
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : sync_stage
`default_nettype wire

/* rtl/sample_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO with valid and ready on both sides
module sample_fifo #(
  parameter int WIDTH = 14,                    // Word width
  parameter int DEPTH = 4                      // Words held
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  // Filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];               // Storage
  logic [AW:0]      wr_ptr_r;                  // Write pointer with wrap bit
  logic [AW:0]      rd_ptr_r;                  // Read pointer with wrap bit
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Honest full and empty from the wrap bits
  assign empty       = (wr_ptr_r == rd_ptr_r);
  assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign push        = i_in_valid && !full;
  assign pop         = i_out_ready && !empty;
  assign o_out_data  = mem[rd_ptr_r[AW-1:0]];

  //////////////////////////////////////////////////////////////////////////////
  // Storage write
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= i_in_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pointers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'h1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'h1;
      end
    end
  end

endmodule : sample_fifo
`default_nettype wire

/* verif/adc_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Watches the pins of the converter output port
module adc_port_monitor (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rstn,
  // Inputs of the port
  input wire logic        i_sample_clk,
  input wire logic [1:0]  i_format_polarity_select,
  input wire logic        i_output_enable,
  input wire logic        i_dll_off,
  input wire logic        i_power_down_bit,
  // Outputs of the port
  input wire logic [11:0] o_sample_data,
  input wire logic [11:0] o_sample_data_oe,
  input wire logic        o_out_of_range_flag,
  input wire logic        o_data_ready_clock,
  input wire logic        o_dll_enabled,
  input wire logic        o_core_active,
  input wire logic        o_reference_on,
  input wire logic        o_clock_lost
);
  logic [7:0] still_r;  // Cycles the sample clock pin stood still

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////////////////////////////////
  // Stillness counter, saturates at its top
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn)
      still_r <= 8'h00;
    else if ($changed(i_sample_clk))
      still_r <= 8'h00;  // Pin moved
    else if (still_r != 8'hff)
      still_r <= still_r + 8'h01;
  end

  ////////////////////////////////////////////////////////////
  // Loop status follows its bit one edge later
  property p_dll; $past(i_rstn) |-> o_dll_enabled == !$past(i_dll_off); endproperty
  a_dll: assert property (p_dll)
    else $error("loop status wrong");
  // Flag only beside a full-scale code of either coding
  property p_flag; o_out_of_range_flag |-> o_sample_data inside {12'hfff, 12'h000, 12'h7ff, 12'h800}; endproperty
  a_flag: assert property (p_flag)
    else $error("flag without full scale");
  // Enable low releases the word lines
  property p_hiz; (!i_output_enable) [*5] |-> ~|o_sample_data_oe; endproperty
  a_hiz: assert property (p_hiz)
    else $error("lines driven with enable low");
  // Commanded power-down releases lines, keeps reference
  property p_pdn; i_power_down_bit [*2] |-> ~|o_sample_data_oe && o_reference_on && !o_core_active; endproperty
  a_pdn: assert property (p_pdn)
    else $error("power-down state wrong");
  // A still sample clock powers the core down
  property p_lost; still_r > 8'h22 && !i_power_down_bit && !$past(i_power_down_bit) |-> o_clock_lost; endproperty
  a_lost: assert property (p_lost)
    else $error("slow clock not seen");
  // First edge after reset shows a cleared port
  property p_rst; !$past(i_rstn) |-> o_sample_data == 12'h000 && !o_reference_on; endproperty
  a_rst: assert property (p_rst)
    else $error("port not cleared by reset");
  // A new word leaves with the ready clock after a sample clock rise
  property p_launch; $changed(o_sample_data) |-> $past(i_sample_clk, 2) && $changed(o_data_ready_clock); endproperty
  a_launch: assert property (p_launch)
    else $error("word launched off the clock");
  // Ready clock level at launch is set by the polarity bit
  property p_pol;
    $changed(o_sample_data) && i_format_polarity_select == $past(i_format_polarity_select, 4)
      |-> o_data_ready_clock == i_format_polarity_select[0];
  endproperty
  a_pol: assert property (p_pol)
    else $error("ready clock polarity wrong");
endmodule : adc_port_monitor
`default_nettype wire

/* verif/capture_model.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Board capture logic latching each word on the ready clock
module capture_model (
  // Pins and their drive enables
  input  wire logic [11:0] i_pin_data,
  input  wire logic [11:0] i_pin_oe,
  input  wire logic        i_rdy_clk,
  input  wire logic        i_rdy_oe,
  // Capture edge select, 1 for falling
  input  wire logic        i_fall,
  // Last word latched
  output logic      [11:0] o_cap_word
);
  logic [12:0] last_r;  // Last driven level of each line
  logic [12:0] pin_w;   // Ready clock above the word
  logic [12:0] oe_w;    // Enables in the same order
  logic [12:0] line_w;  // Board level, inverse of last when released
  assign pin_w  = {i_rdy_clk, i_pin_data};
  assign oe_w   = {i_rdy_oe, i_pin_oe};
  assign line_w = (pin_w & oe_w) | (~last_r & ~oe_w);
  // Remember driven levels
  always @(pin_w or oe_w)
    for (int i = 0; i < 13; i++)
      if (oe_w[i]) last_r[i] = pin_w[i];
  // Latch on the chosen ready clock edge, the sample clock is never used
  always @(line_w[12])
    if (line_w[12] ^ i_fall) o_cap_word = line_w[11:0];
endmodule : capture_model
`default_nettype wire

/* verif/tb_adc_parallel_output_port.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Self-checking bench of the converter output port
module tb_adc_parallel_output_port;
  // Row: format, code, overdrives, expected word and flag
  typedef struct packed {logic [1:0] f; logic [11:0] c; logic p; logic n; logic [11:0] e; logic o;} row_t;
  // Inputs, valued from time zero
  logic        i_mclk = 1'h0, i_rstn = 1'h0, i_sample_clk = 1'h0, i_output_enable = 1'h1, i_dll_off = 1'h0;
  logic        i_power_down_bit = 1'h0, i_conv_valid = 1'h0, i_conv_ovr_pos = 1'h0, i_conv_ovr_neg = 1'h0;
  logic        sclk_run = 1'h0;                // Sample clock runs while high
  logic [1:0]  i_format_polarity_select = 2'h0;
  logic [11:0] i_conv_code = 12'h000;
  // Outputs
  logic [11:0] o_sample_data, o_sample_data_oe, cap_word;
  logic        o_conv_ready, o_out_of_range_flag, o_out_of_range_flag_oe, o_data_ready_clock;
  logic        o_data_ready_clock_oe, o_dll_enabled, o_core_active, o_reference_on, o_clock_lost;
  int          bad_count = 0, n_checks = 0;    // Mismatches, comparisons
  row_t        rows [10];                      // Ordinary cases

  // Block clock, and an 80 ns sample clock that stops low
  always #5 i_mclk = ~i_mclk;
  always begin
    #40;
    if (sclk_run || i_sample_clk) i_sample_clk = ~i_sample_clk;
  end

  // Port and its far side
  adc_parallel_output_port u_adc_parallel_output_port (.i_mclk, .i_rstn, .i_sample_clk,
    .i_format_polarity_select, .i_output_enable, .i_dll_off, .i_power_down_bit, .i_conv_valid, .o_conv_ready,
    .i_conv_code, .i_conv_ovr_pos, .i_conv_ovr_neg, .o_sample_data, .o_sample_data_oe, .o_out_of_range_flag,
    .o_out_of_range_flag_oe, .o_data_ready_clock, .o_data_ready_clock_oe, .o_dll_enabled, .o_core_active,
    .o_reference_on, .o_clock_lost);
  capture_model u_capture_model (.i_pin_data(o_sample_data), .i_pin_oe(o_sample_data_oe),
    .i_rdy_clk(o_data_ready_clock), .i_rdy_oe(o_data_ready_clock_oe),
    .i_fall(i_format_polarity_select[0]), .o_cap_word(cap_word));

  ////////////////////////////////////////////////////////////
  // Compare a word, then a single bit
  task automatic chk12(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk12
  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk1
  // Let n edges pass, settle just after the last
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  // Offer a word and hold it until taken; valid stays up
  task automatic push(input logic [11:0] c, input logic p, input logic n);
    i_conv_valid = 1'h1;
    i_conv_code = c;
    i_conv_ovr_pos = p;
    i_conv_ovr_neg = n;
    for (int w = 0; w < 300 && o_conv_ready !== 1'h1; w++) step(1);
    step(1);
  endtask : push
  // Print the counts and the verdict, then stop
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rows = '{'{2'h0, 12'h123, 1'h0, 1'h0, 12'h123, 1'h0}, '{2'h2, 12'h123, 1'h0, 1'h0, 12'h923, 1'h0},
      '{2'h1, 12'h456, 1'h1, 1'h0, 12'hfff, 1'h1}, '{2'h3, 12'h456, 1'h1, 1'h0, 12'h7ff, 1'h1},
      '{2'h0, 12'h789, 1'h0, 1'h1, 12'h000, 1'h1}, '{2'h2, 12'h789, 1'h0, 1'h1, 12'h800, 1'h1},
      '{2'h3, 12'h800, 1'h0, 1'h0, 12'h000, 1'h0}, '{2'h1, 12'hfff, 1'h0, 1'h0, 12'hfff, 1'h1},
      '{2'h3, 12'h5a5, 1'h1, 1'h1, 12'h7ff, 1'h1}, '{2'h0, 12'h001, 1'h0, 1'h0, 12'h001, 1'h0}};
    step(10);
    chk12("oe in reset", 12'h000, o_sample_data_oe);
    chk1("loop in reset", 1'h1, o_dll_enabled);
    step(2);
    i_rstn = 1'h1;
    step(3);
    chk1("reference", 1'h1, o_reference_on);
    i_dll_off = 1'h1;
    sclk_run = 1'h1;
    step(20);
    chk1("loop off", 1'h0, o_dll_enabled);
    chk1("active", 1'h1, o_core_active);
    // One word every two sample clock periods, all four modes
    foreach (rows[k]) begin
      @(negedge i_sample_clk);
      step(1);
      i_format_polarity_select = rows[k].f;
      push(rows[k].c, rows[k].p, rows[k].n);
      i_conv_valid = 1'h0;
      @(negedge i_sample_clk);
      step(6);
      chk12("captured", rows[k].e, cap_word);
      chk12("data", rows[k].e, o_sample_data);
      chk1("flag", rows[k].o, o_out_of_range_flag);
    end
    // Enable low, then commanded power-down
    i_output_enable = 1'h0;
    step(6);
    chk12("oe off", 12'h000, o_sample_data_oe);
    chk1("flag oe", 1'h0, o_out_of_range_flag_oe);
    chk1("clock oe", 1'h0, o_data_ready_clock_oe);
    i_output_enable = 1'h1;
    i_power_down_bit = 1'h1;
    step(6);
    chk12("oe down", 12'h000, o_sample_data_oe);
    chk1("core down", 1'h0, o_core_active);
    i_power_down_bit = 1'h0;
    step(6);
    chk12("oe back", 12'hfff, o_sample_data_oe);
    // Clock stopped: power-down while the buffer fills
    sclk_run = 1'h0;
    step(50);
    chk1("lost", 1'h1, o_clock_lost);
    for (int j = 0; j < 4; j++) push(12'h100 + 12'(j), 1'h0, 1'h0);
    i_conv_code = 12'h2c4;
    step(2);
    chk1("refused", 1'h0, o_conv_ready);
    sclk_run = 1'h1;
    push(12'h2c4, 1'h0, 1'h0);
    i_conv_valid = 1'h0;
    step(100);
    chk12("drained", 12'h2c4, o_sample_data);
    chk1("empty", 1'h1, o_conv_ready);
    // Second reset in mid-run
    i_rstn = 1'h0;
    step(3);
    chk12("data reset", 12'h000, o_sample_data);
    i_rstn = 1'h1;
    step(10);
    print_verdict();
  end

  // Cut a hang short well past the expected run
  initial begin
    #50000;
    bad_count++;
    print_verdict();
  end
endmodule : tb_adc_parallel_output_port

// Checker beside the port
bind adc_parallel_output_port adc_port_monitor u_adc_port_monitor (.i_mclk, .i_rstn, .i_sample_clk,
  .i_format_polarity_select, .i_output_enable, .i_dll_off, .i_power_down_bit, .o_sample_data,
  .o_sample_data_oe, .o_out_of_range_flag, .o_data_ready_clock, .o_dll_enabled, .o_core_active,
  .o_reference_on, .o_clock_lost);
`default_nettype wire
